//--- nbs_sram.sv
// nbs_sram: no-turnaround synchronous sram, bus side, pipelined or flow-through
// assumes bus pins arrive asynchronously and pass two flops; data pins as in/out/enable
// Behaviour
// RULE1: inputs sampled only on rising clock edge
// RULE2: read and write back to back, no idle
// RULE3: output enable forces drivers off anytime
// RULE4: sleep request powers down while asserted
// RULE5: writes start on edge, self timed
// RULE6: pipelined read data held in output register
// RULE7: pipelined write data two cycles after address
// RULE8: flow-through write data one cycle after
// RULE9: mode input selects latencies of operation
// RULE10: nine-bit byte lanes written by enables
// RULE11: selected only when all three selects active
// RULE12: burst order fixed, linear or interleaved
// RULE13: selects, write strobe, lane enables polarities
// RULE14: clock enable low advances nothing; the code holds the pipe while clk_en_n is high and runs while it is low
// RULE15: burst step advances counter from seed
// RULE16: mode low flow-through, high pipelined
// RULE17: four-beat wrap, increment or xor order
// RULE18: deselect floats bus; unaddressed data ignored
`timescale 1ns/1ns
`default_nettype none
module nbs_sram
    import nbs_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clk_en,
    // bus controls from controller
    input wire logic clk_en_n,
    input wire logic chip_sel1_n,
    input wire logic chip_sel2,
    input wire logic chip_sel3_n,
    input wire logic write_n,
    input wire logic burst_step,
    input wire logic [NBS_LANES-1:0] lane_we_n,
    input wire logic [NBS_ADDR_W-1:0] addr,
    // asynchronous controls
    input wire logic out_en_n,
    input wire logic sleep_request,
    // static configuration
    input wire logic latency_mode_sel_n,
    input wire logic burst_order_sel_n,
    // data pins
    input wire logic [NBS_DATA_W-1:0] dq_in,
    output logic [NBS_DATA_W-1:0] dq_out,
    output logic dq_oe,
    // status
    output logic asleep
);
    ////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        nbs_bus_t bus_s1;
        nbs_bus_t bus_s2;
        logic cke_n_s1;
        logic cke_n_s2;
        logic oe_n_s1;
        logic oe_n_s2;
        logic sleep_s1;
        logic sleep_s2;
        logic [NBS_DATA_W-1:0] dq_s1;
        logic [NBS_DATA_W-1:0] dq_s2;
        nbs_cmd_t cmd1;
        nbs_cmd_t cmd2;
        logic [NBS_ADDR_W-1:0] base_addr;
        logic [1:0] seed;
        logic [1:0] beat;
        logic burst_write;
        logic active;
        logic rd_p1;
        logic rd_p2;
        logic [NBS_DATA_W-1:0] rd_hold;
        logic [NBS_DATA_W-1:0] dq_out;
        logic dq_oe;
        logic asleep;
    } nbs_state_t;

    nbs_state_t state_r;
    nbs_state_t state_nxt;
    nbs_cmd_t cmd0;
    nbs_cmd_t wr_cmd;
    logic pipe_mode;
    logic selected;
    logic run;
    logic [NBS_DATA_W-1:0] rd_data;
    logic wr_go;
    logic rd_go;
    logic drive_rd;

    // burst address low bits for a given beat
    function automatic logic [1:0] nbs_burst_lsb(input logic [1:0] seed, input logic [1:0] beat,
                                                  input logic linear);
        if (linear) begin
            nbs_burst_lsb = seed + beat; // see RULE17
        end else begin
            nbs_burst_lsb = seed ^ beat; // see RULE17
        end
    endfunction

    // chip select decode, all three at active level
    function automatic logic nbs_sel(input nbs_bus_t b);
        nbs_sel = !b.chip_sel1_n && b.chip_sel2 && !b.chip_sel3_n; // see RULE11 see RULE13
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // command decode
    assign pipe_mode = latency_mode_sel_n; // see RULE16 see RULE9
    assign selected = nbs_sel(state_r.bus_s2);
    assign run = !state_r.cke_n_s2 && !state_r.asleep; // see RULE14 see RULE4

    always_comb begin
        cmd0 = '0;
        if (run && selected && !state_r.bus_s2.burst_step) begin
            cmd0.valid = 1'b1;
            cmd0.write = !state_r.bus_s2.write_n; // see RULE13
            cmd0.addr = state_r.bus_s2.addr;
            cmd0.lane_we = ~state_r.bus_s2.lane_we_n; // see RULE10
        end else if (run && state_r.bus_s2.burst_step && state_r.active) begin
            cmd0.valid = 1'b1; // see RULE15
            cmd0.write = state_r.burst_write;
            cmd0.addr = {state_r.base_addr[NBS_ADDR_W-1:2],
                         nbs_burst_lsb(state_r.seed, state_r.beat + NBS_BEAT_ONE, !burst_order_sel_n)}; // see RULE12
            cmd0.lane_we = ~state_r.bus_s2.lane_we_n;
        end
    end

    // write data phase follows address by mode latency
    assign wr_cmd = pipe_mode ? state_r.cmd2 : state_r.cmd1; // see RULE7 see RULE8
    assign wr_go = run && wr_cmd.valid && wr_cmd.write; // see RULE18 see RULE5
    assign rd_go = run && cmd0.valid && !cmd0.write;

    ////////////////////////////////////////////////////////////////////////
    // storage
    nbs_mem u_mem (
        .clk_sys(clk_sys),
        .clk_en(clk_en),
        .wr_en(wr_go),
        .wr_addr(wr_cmd.addr),
        .wr_lane(wr_cmd.lane_we),
        .wr_data(state_r.dq_s2),
        .rd_en(rd_go),
        .rd_addr(cmd0.addr),
        .rd_data(rd_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        state_nxt = state_r;
        state_nxt.bus_s1 = {chip_sel1_n, chip_sel2, chip_sel3_n, write_n, burst_step, lane_we_n, addr}; // see RULE1
        state_nxt.bus_s2 = state_r.bus_s1;
        state_nxt.cke_n_s1 = clk_en_n;
        state_nxt.cke_n_s2 = state_r.cke_n_s1;
        state_nxt.oe_n_s1 = out_en_n;
        state_nxt.oe_n_s2 = state_r.oe_n_s1;
        state_nxt.sleep_s1 = sleep_request;
        state_nxt.sleep_s2 = state_r.sleep_s1;
        state_nxt.dq_s1 = dq_in;
        state_nxt.dq_s2 = state_r.dq_s1;
        state_nxt.asleep = state_r.sleep_s2; // see RULE4
        drive_rd = 1'b0;
        if (run) begin
            // pipe advances every active edge, so reads and writes interleave freely
            state_nxt.cmd1 = cmd0; // see RULE2
            state_nxt.cmd2 = state_r.cmd1;
            state_nxt.rd_p1 = rd_go;
            state_nxt.rd_p2 = state_r.rd_p1; // see RULE6
            if (cmd0.valid && !state_r.bus_s2.burst_step) begin
                state_nxt.base_addr = cmd0.addr;
                state_nxt.seed = cmd0.addr[1:0]; // see RULE15
                state_nxt.beat = 2'h0;
                state_nxt.burst_write = cmd0.write;
                state_nxt.active = 1'b1;
            end else if (cmd0.valid) begin
                state_nxt.beat = state_r.beat + NBS_BEAT_ONE; // see RULE17
            end else begin
                state_nxt.active = 1'b0;
            end
            // hold the array word so a following read cannot overwrite it
            if (state_r.rd_p1) begin
                state_nxt.rd_hold = rd_data; // see RULE6
            end
            if (pipe_mode) begin
                // extra output register stage: one cycle later than flow
                drive_rd = state_r.rd_p2; // see RULE6 see RULE7
                if (state_r.rd_p2) begin
                    state_nxt.dq_out = state_r.rd_hold;
                end
            end else begin
                drive_rd = state_r.rd_p1; // see RULE8
                if (state_r.rd_p1) begin
                    state_nxt.dq_out = rd_data;
                end
            end
            state_nxt.dq_oe = drive_rd && !state_r.oe_n_s2; // see RULE18
        end
        if (state_r.oe_n_s2 || state_r.sleep_s2) begin
            state_nxt.dq_oe = 1'b0; // see RULE3 see RULE4
        end
        if (rst) begin
            state_nxt = '0;
            state_nxt.cke_n_s1 = 1'b1;
            state_nxt.cke_n_s2 = 1'b1;
            state_nxt.oe_n_s1 = 1'b1;
            state_nxt.oe_n_s2 = 1'b1;
            state_nxt.dq_out = NBS_DATA_RST;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (clk_en || rst) begin
            state_r <= state_nxt;
        end
    end

    assign dq_out = state_r.dq_out;
    assign dq_oe = state_r.dq_oe;
    assign asleep = state_r.asleep;
endmodule : nbs_sram
`default_nettype wire

//--- nbs_pkg.sv
// nbs_pkg: constants and carrier types for the no-turnaround synchronous sram model
// assumes one system clock; all users import nbs_pkg::*
package nbs_pkg;
    localparam int NBS_LANES = 4;
    localparam int NBS_LANE_W = 9;
    localparam int NBS_DATA_W = 36;
    localparam int NBS_ADDR_W = 10;
    localparam int NBS_DEPTH = 1024;
    localparam int NBS_PIPE_WR_LAT = 2;
    localparam int NBS_FLOW_WR_LAT = 1;
    localparam logic [1:0] NBS_BEAT_ONE = 2'h1;
    localparam logic [NBS_DATA_W-1:0] NBS_DATA_RST = 36'h0_0000_0000;

    // one captured bus command
    typedef struct packed {
        logic valid;
        logic write;
        logic [NBS_ADDR_W-1:0] addr;
        logic [NBS_LANES-1:0] lane_we;
    } nbs_cmd_t;

    // bus pins from the controller, raw or at either synchroniser stage
    typedef struct packed {
        logic chip_sel1_n;
        logic chip_sel2;
        logic chip_sel3_n;
        logic write_n;
        logic burst_step;
        logic [NBS_LANES-1:0] lane_we_n;
        logic [NBS_ADDR_W-1:0] addr;
    } nbs_bus_t;
endpackage : nbs_pkg

//--- nbs_mem.sv
// nbs_mem: byte-lane writable storage array with registered read data
// assumes synchronous use on clk_sys with one read and one write port
`timescale 1ns/1ns
`default_nettype none
module nbs_mem
    import nbs_pkg::*;
(
    // clock
    input wire logic clk_sys,
    input wire logic clk_en,
    // write port
    input wire logic wr_en,
    input wire logic [NBS_ADDR_W-1:0] wr_addr,
    input wire logic [NBS_LANES-1:0] wr_lane,
    input wire logic [NBS_DATA_W-1:0] wr_data,
    // read port
    input wire logic rd_en,
    input wire logic [NBS_ADDR_W-1:0] rd_addr,
    output logic [NBS_DATA_W-1:0] rd_data
);
    logic [NBS_DATA_W-1:0] mem_r [NBS_DEPTH];

    genvar g;
    generate
        for (g = 0; g < NBS_LANES; g++) begin : g_lane
            always_ff @(posedge clk_sys) begin
                if (clk_en && wr_en && wr_lane[g]) begin
                    mem_r[wr_addr][g*NBS_LANE_W +: NBS_LANE_W] <= wr_data[g*NBS_LANE_W +: NBS_LANE_W];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (clk_en && rd_en) begin
            rd_data <= mem_r[rd_addr];
        end
    end
endmodule : nbs_mem
`default_nettype wire

//--- nbs_ctl_model.sv
// nbs_ctl_model: controller data side, places write data in its late slot
// assumes wr_v and wr_d are presented together with the write command
`timescale 1ns/1ns
`default_nettype none
module nbs_ctl_model
    import nbs_pkg::*;
(
    // clock and mode
    input wire logic clk_sys,
    input wire logic pipe,
    // write data from the bench and the data pins
    input wire logic wr_v,
    input wire logic [NBS_DATA_W-1:0] wr_d,
    output logic [NBS_DATA_W-1:0] dq_in
);
    logic [1:0] v_r = '0;
    logic [NBS_DATA_W-1:0] d_r [2];
    logic [NBS_DATA_W-1:0] last_r = '0;
    wire slot = pipe ? v_r[1] : v_r[0];
    wire [NBS_DATA_W-1:0] cur = pipe ? d_r[1] : d_r[0];
    // outside its slot the bus shows the inverse of the last word
    assign dq_in = slot ? cur : ~last_r;
    always @(posedge clk_sys) begin
        v_r <= {v_r[0], wr_v};
        d_r[0] <= wr_d;
        d_r[1] <= d_r[0];
        if (slot) last_r <= cur;
    end
endmodule // nbs_ctl_model
`default_nettype wire

//--- nbs_sram_checker.sv
// nbs_sram_checker: port-level timing checks of the sram bus side
// assumes it is bound to nbs_sram and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module nbs_sram_checker
    import nbs_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // controls
    input wire logic clk_en_n,
    input wire logic chip_sel1_n,
    input wire logic chip_sel2,
    input wire logic chip_sel3_n,
    input wire logic write_n,
    input wire logic burst_step,
    input wire logic out_en_n,
    input wire logic sleep_request,
    input wire logic latency_mode_sel_n,
    // outputs
    input wire logic [NBS_DATA_W-1:0] dq_out,
    input wire logic dq_oe,
    input wire logic asleep
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    wire sel = !chip_sel1_n && chip_sel2 && !chip_sel3_n;
    wire ok = !out_en_n && !sleep_request && !clk_en_n;
    wire rd = sel && write_n && !clk_en_n && !burst_step;
    rst_idle_a: assert property (disable iff (1'b0) rst |=> !dq_oe && !asleep && dq_out == NBS_DATA_RST)
        else $error("outputs not idle after reset");
    oe_override_a: assert property (out_en_n [*3] |=> !dq_oe)
        else $error("drivers on while output enable is off");
    sleep_enter_a: assert property (sleep_request [*4] |=> asleep)
        else $error("no power-down while sleep is requested");
    sleep_exit_a: assert property (!sleep_request [*4] |=> !asleep)
        else $error("still asleep after sleep request dropped");
    flow_read_a: assert property (ok [*4] ##0 (rd && !latency_mode_sel_n) ##1 ok [*3] |=> dq_oe)
        else $error("flow read not driven after four cycles");
    pipe_read_a: assert property (ok [*4] ##0 (rd && latency_mode_sel_n) ##1 ok [*4] |=> dq_oe)
        else $error("pipelined read not driven after five cycles");
    desel_quiet_a: assert property (!sel [*6] |=> !dq_oe)
        else $error("drivers on while deselected");
    cke_hold_a: assert property (clk_en_n [*6] |=> !dq_oe)
        else $error("drivers on while clock enable is off");
    cover property (rd && latency_mode_sel_n);
    cover property (rd && !latency_mode_sel_n);
    cover property (asleep);
endmodule // nbs_sram_checker
bind nbs_sram nbs_sram_checker nbs_sram_checker_inst (.clk_sys(clk_sys), .rst(rst), .clk_en_n(clk_en_n),
    .chip_sel1_n(chip_sel1_n), .chip_sel2(chip_sel2), .chip_sel3_n(chip_sel3_n), .write_n(write_n),
    .burst_step(burst_step), .out_en_n(out_en_n), .sleep_request(sleep_request),
    .latency_mode_sel_n(latency_mode_sel_n), .dq_out(dq_out), .dq_oe(dq_oe), .asleep(asleep));
`default_nettype wire

//--- test_nbs_sram.sv
// test_nbs_sram: bus commands checked against a shadow memory in all modes
// assumes nbs_sram, nbs_ctl_model and the checker are compiled first
`timescale 1ns/1ns
`default_nettype none
module test_nbs_sram;
    import nbs_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic clk_en_n = 1'b0;
    logic out_en_n = 1'b0;
    logic sleep_request = 1'b0;
    logic mode_n = 1'b0;
    logic order_n = 1'b0;
    logic quiet = 1'b0;
    logic wr_v = 1'b0;
    logic [NBS_DATA_W-1:0] wr_d = '0;
    logic [NBS_DATA_W-1:0] dq_in, dq_out;
    logic dq_oe, asleep;
    nbs_bus_t b = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 4'hF, '0};
    logic [NBS_DATA_W-1:0] mem [NBS_DEPTH];
    logic [NBS_DATA_W-1:0] ed [64];
    logic ev [64] = '{default: 1'b0};
    logic [NBS_ADDR_W-1:0] base = '0;
    logic [1:0] beat = '0;
    int cyc = 0;
    int err_total = 0;
    int n_compared = 0;
    nbs_sram nbs_sram_inst (.clk_sys(clk_sys), .rst(rst), .clk_en(1'b1), .clk_en_n(clk_en_n),
        .chip_sel1_n(b.chip_sel1_n), .chip_sel2(b.chip_sel2), .chip_sel3_n(b.chip_sel3_n),
        .write_n(b.write_n), .burst_step(b.burst_step), .lane_we_n(b.lane_we_n), .addr(b.addr),
        .out_en_n(out_en_n), .sleep_request(sleep_request), .latency_mode_sel_n(mode_n),
        .burst_order_sel_n(order_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .asleep(asleep));
    nbs_ctl_model nbs_ctl_model_inst (.clk_sys(clk_sys), .pipe(mode_n), .wr_v(wr_v), .wr_d(wr_d), .dq_in(dq_in));
    initial forever #2 clk_sys = ~clk_sys;
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string n, input logic [NBS_DATA_W-1:0] e, input logic [NBS_DATA_W-1:0] s);
        n_compared++;
        if (s !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    // x bits: clock enable off, then one bit per select turned inactive
    task automatic cmd(input logic w, input logic [9:0] a, input logic [3:0] ln, input logic st,
                       input logic [3:0] x, input logic [NBS_DATA_W-1:0] d);
        logic [NBS_ADDR_W-1:0] ea;
        @(negedge clk_sys);
        {clk_en_n, b.chip_sel1_n, b.chip_sel2, b.chip_sel3_n} = x ^ 4'h2;
        b.write_n = !w;
        b.burst_step = st;
        b.lane_we_n = ln;
        b.addr = a;
        wr_v = 1'b0;
        if (x != 4'h0) return;
        beat = st ? beat + 2'h1 : 2'h0;
        if (!st) base = a;
        ea = {base[9:2], order_n ? base[1:0] ^ beat : base[1:0] + beat};
        if (w) begin
            wr_v = 1'b1;
            wr_d = d;
            for (int g = 0; g < NBS_LANES; g++) if (!ln[g]) mem[ea][9*g+:9] = d[9*g+:9];
        end else if (!quiet) begin
            ev[(cyc + 4 + mode_n) % 64] = 1'b1;
            ed[(cyc + 4 + mode_n) % 64] = mem[ea];
        end
    endtask
    task automatic idle(input int n);
        repeat (n) cmd(0, '0, 4'hF, 0, 4'h7, '0);
    endtask
    always @(negedge clk_sys) begin
        if (!rst) begin
            chk("dq_oe", NBS_DATA_W'(ev[cyc % 64]), NBS_DATA_W'(dq_oe));
            if (ev[cyc % 64]) chk("dq_out", ed[cyc % 64], dq_out);
        end
        ev[cyc % 64] = 1'b0;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc > 2000) begin
            err_total++;
            conclude();
        end
    end
    initial begin
        for (int m = 0; m < 4; m++) begin
            {order_n, mode_n} = 2'(m);
            rst = 1'b1;
            repeat (8) @(negedge clk_sys);
            rst = 1'b0;
            for (int i = 0; i < 4; i++) cmd(1, 10'h010 + 10'(i), 4'h0, 0, 4'h0, 36'h5_A5A5_0000 + 36'(m * 16 + i));
            idle(4);
            for (int i = 0; i < 4; i++) begin
                cmd(1, 10'h020 + 10'(i), 4'h0, 0, 4'h0, ~36'(m * 16 + i));
                cmd(0, 10'h010 + 10'(i), 4'hF, 0, 4'h0, '0);
            end
            cmd(1, 10'h011, 4'hA, 0, 4'h0, 36'h0_0000_0000);
            for (int k = 1; k < 16; k *= 2) cmd(1, 10'h012, 4'h0, 0, 4'(k), '1);
            repeat (6) cmd(1, 10'h013, 4'h0, 0, 4'h8, '1);
            for (int k = 0; k < 4; k++) cmd(1, k ? 10'h000 : 10'h035, 4'h0, k != 0, 4'h0, 36'(k * 3 + m) << 20);
            idle(6);
            for (int i = 0; i < 4; i++) begin
                cmd(0, 10'h010 + 10'(i), 4'hF, 0, 4'h0, '0);
                cmd(0, 10'h020 + 10'(i), 4'hF, 0, 4'h0, '0);
                cmd(0, 10'h034 + 10'(i), 4'hF, 0, 4'h0, '0);
            end
            for (int k = 0; k < 4; k++) cmd(0, 10'h036, 4'hF, k != 0, 4'h0, '0);
            for (int k = 0; k < 2; k++) begin
                idle(6);
                {sleep_request, out_en_n} = k ? 2'h2 : 2'h1;
                quiet = 1'b1;
                idle(4);
                chk("asleep", 36'(k), 36'(asleep));
                cmd(0, 10'h010, 4'hF, 0, 4'h0, '0);
                idle(6);
                {sleep_request, out_en_n} = 2'h0;
                idle(4);
                quiet = 1'b0;
                chk("asleep", 36'h0, 36'(asleep));
            end
        end
        conclude();
    end
endmodule // test_nbs_sram
`default_nettype wire
